// >>> rtl/step_seq_pkg.sv
// Package: constants and carrier types of the step/direction microstep sequencer
package step_seq_pkg;
	localparam int POS_WIDTH = 10;
	localparam int TABLE_SIZE = 1024;
	localparam int RES_WIDTH = 4;
	localparam logic [3:0] RES_FINEST = 4'h0;
	localparam logic [3:0] RES_FULL = 4'h8;
	localparam logic [9:0] POS_RESET = 10'h000;
	localparam logic [9:0] POS_WRAP_MAX = 10'h3FF;
	localparam int INTERVAL_WIDTH = 20;
	localparam logic [20:0] INTERVAL_MAX = 21'h100000;
	localparam int SUBSTEPS_LOG2 = 8;
	localparam logic [8:0] FULLSTEP_MICROSTEPS = 9'h100;
	localparam int AMP_WIDTH = 9;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	typedef struct packed
	{
		logic step;
		logic dir;
	} step_in_type;

	typedef struct packed
	{
		logic signed [8:0] coil_a;
		logic signed [8:0] coil_b;
	} coil_out_type;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_STILL = 3'b100
	} interp_state_type;
endpackage

// >>> rtl/sine_lookup.sv
// Sine lookup: quarter-wave synthesised table giving signed sine and cosine
`timescale 1ns/1ps
`default_nettype none
module sine_lookup
(
	input wire logic [9:0] pos, // Table position
	output step_seq_pkg::coil_out_type coil // Signed coil currents
);
	// 1024 positions folded onto a 256-entry quarter-wave table built at elaboration
	function automatic logic [8:0] quarter(input logic [7:0] idx);
		real x;
		x = $sin(3.14159265358979 * (real'(idx) + 0.5) / 512.0) * 255.0;
		return 9'(int'(x));
	endfunction

	logic [8:0] quad [256];

	genvar gi;
	generate
		for (gi = 0; gi < 256; gi++)
		begin : g_tab
			assign quad[gi] = quarter(8'(gi));
		end
	endgenerate

	function automatic logic signed [8:0] sine_at(input logic [9:0] p);
		logic [7:0] i;
		logic [8:0] m;
		i = p[8] ? ~p[7:0] : p[7:0];
		m = quad[i];
		return p[9] ? -$signed(m) : $signed(m);
	endfunction

	always_comb
	begin
		coil.coil_a = sine_at(pos); // RULE_22
		coil.coil_b = sine_at(pos + 10'h100); // RULE_22
	end
endmodule
`default_nettype wire

// >>> rtl/step_dir_microstep_sequencer.sv
// Step/direction front end with microstep counter, interpolator and standstill detect
//
// Function
// RULE_01 - Only rising step edges advance the sequence
// RULE_02 - Synchronise step and direction before use
// RULE_03 - Controller keeps step rate at most half clock
// RULE_04 - 1024-entry sine table indexed by position
// RULE_05 - Direction low adds, high subtracts width
// RULE_06 - Width doubles per resolution step, 1 to 256
// RULE_07 - Coarser resolution snaps to nearest valid position
// RULE_08 - Full step visits 128,384,640,896 only
// RULE_09 - Half step starts 64, moves 128
// RULE_10 - Quarter step starts 32, moves 64
// RULE_11 - Coarse positions sit half width off zero
// RULE_12 - Interpolate each step to 256-per-fullstep resolution
// RULE_13 - Two to 256 microsteps per input pulse
// RULE_14 - Time previous interval, split into equal parts
// RULE_15 - Interval measurement spans 2^20 clocks
// RULE_16 - No edge in max interval signals standstill
// RULE_17 - Standstill starts standby reduction if selected
// RULE_18 - Standstill flag clears on next step edge
// RULE_19 - Faster rate adopted after one interval; drop pending
// RULE_20 - Controller should give jitter-free step periods
// RULE_21 - Ten-bit position counter wraps both ways
// RULE_22 - Coil A sine, coil B cosine, signed
`timescale 1ns/1ps
`default_nettype none
module step_dir_microstep_sequencer
#(
	parameter int INTERVAL_LIMIT = 1048576
)
(
	input wire logic clk_sys, // System clock, 200 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire step_seq_pkg::step_in_type step_in, // Raw step and direction pins
	input wire logic [3:0] resolution, // 0 = 256 microsteps ... 8 = full step
	input wire logic interp_enable, // Interpolate to 256x resolution
	input wire logic standby_select_pin, // Enables standby current reduction
	output logic [9:0] microstep_position_count, // Target position from step input
	output logic [9:0] coil_position, // Position driving coil currents
	output step_seq_pkg::coil_out_type coil, // Signed coil A and B currents
	output logic standstill, // Standstill flag
	output logic standstill_event, // One-cycle pulse on standstill
	output logic standby_active // Standby current reduction request
);
	step_seq_pkg::step_in_type sync1_q;
	step_seq_pkg::step_in_type sync2_q;
	logic step_prev_q;
	logic step_edge;
	logic [3:0] res_q;
	logic [9:0] width;
	logic [9:0] half_width;
	logic [9:0] pos_q;
	logic [9:0] pos_d;
	logic [9:0] snapped;
	logic [9:0] coil_q;
	logic [20:0] interval_q;
	logic [20:0] period_q;
	logic [20:0] sub_period;
	logic [20:0] sub_cnt_q;
	logic [8:0] pending_q;
	logic dir_q;
	logic still_q;
	logic still_event_q;
	logic limit_hit;
	step_seq_pkg::interp_state_type state_q;

	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			step_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= step_in; // RULE_02
			sync2_q <= sync1_q; // RULE_02
			step_prev_q <= sync2_q.step;
		end
	end

	assign step_edge = sync2_q.step & ~step_prev_q; // RULE_01

	// Resolution 0..8 maps to widths 1..256; larger codes saturate at full step
	always_comb
	begin
		if (resolution > step_seq_pkg::RES_FULL)
		begin
			width = 10'h100; // RULE_06
		end
		else
		begin
			width = 10'(10'h001 << resolution); // RULE_06
		end
		half_width = width >> 1;
	end

	// Nearest valid grid point: multiples of width offset by half width
	always_comb
	begin
		logic [9:0] mask;
		mask = ~(width - 10'h001);
		snapped = ((pos_q - half_width + (width >> 1)) & mask) + half_width; // RULE_07 RULE_11
	end

	always_comb
	begin
		pos_d = pos_q;
		if (resolution != res_q)
		begin
			pos_d = snapped; // RULE_07
		end
		else if (step_edge)
		begin
			if (sync2_q.dir)
			begin
				pos_d = pos_q - width; // RULE_05 RULE_21
			end
			else
			begin
				pos_d = pos_q + width; // RULE_05 RULE_21
			end
		end
	end

	// Position counter; a step in the cycle of a resolution change is dropped,
	// since the change is seen first and only the snap is applied
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			pos_q <= step_seq_pkg::POS_RESET;
			res_q <= step_seq_pkg::RES_FINEST;
		end
		else
		begin
			pos_q <= pos_d; // RULE_08 RULE_09 RULE_10
			res_q <= resolution;
		end
	end

	// Interval timer, saturating at the measurable limit
	assign limit_hit = interval_q >= 21'(INTERVAL_LIMIT); // RULE_15 RULE_16

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			interval_q <= '0;
			period_q <= step_seq_pkg::INTERVAL_MAX;
		end
		else if (step_edge)
		begin
			interval_q <= 21'h000001;
			period_q <= limit_hit ? 21'(INTERVAL_LIMIT) : interval_q; // RULE_14 RULE_19
		end
		else if (!limit_hit)
		begin
			interval_q <= interval_q + 21'h000001; // RULE_15
		end
	end

	// Sub-interval: previous period over 2^resolution, the microsteps per pulse for codes 0..8
	always_comb
	begin
		// Full interval width kept: at the finest resolution (code 0) the sub-period is the whole period
		sub_period = period_q >> resolution; // RULE_14
		if (sub_period == 21'h000000)
		begin
			sub_period = 21'h000001;
		end
	end

	// Interpolator: on each edge in ST_RUN the coil jumps to where the last pulse should
	// have ended, so pending microsteps of a slower interval are dropped
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_q <= step_seq_pkg::ST_IDLE;
			coil_q <= step_seq_pkg::POS_RESET;
			pending_q <= '0;
			sub_cnt_q <= '0;
			dir_q <= 1'b0;
		end
		else if (!interp_enable || resolution != res_q)
		begin
			state_q <= step_seq_pkg::ST_IDLE;
			coil_q <= pos_d;
			pending_q <= '0;
			sub_cnt_q <= '0;
		end
		else
		begin
			case (state_q)
				step_seq_pkg::ST_IDLE, step_seq_pkg::ST_STILL:
				begin
					if (step_edge)
					begin
						// No timing known yet: step straight to target
						coil_q <= pos_d;
						state_q <= step_seq_pkg::ST_RUN;
					end
				end
				step_seq_pkg::ST_RUN:
				begin
					if (step_edge)
					begin
						coil_q <= pos_q; // RULE_19
						dir_q <= sync2_q.dir;
						pending_q <= 9'(width); // RULE_12 RULE_13
						sub_cnt_q <= '0;
					end
					else if (limit_hit)
					begin
						coil_q <= pos_q;
						pending_q <= '0;
						state_q <= step_seq_pkg::ST_STILL;
					end
					else if (pending_q != 9'h000)
					begin
						if (sub_cnt_q + 21'h000001 >= sub_period)
						begin
							sub_cnt_q <= '0;
							pending_q <= pending_q - 9'h001;
							coil_q <= dir_q ? coil_q - 10'h001 : coil_q + 10'h001; // RULE_12 RULE_21
						end
						else
						begin
							sub_cnt_q <= sub_cnt_q + 21'h000001;
						end
					end
				end
				default:
				begin
					state_q <= step_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Standstill flag: set when limit reached, cleared by next edge
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			still_q <= 1'b0;
			still_event_q <= 1'b0;
		end
		else
		begin
			still_event_q <= limit_hit & ~still_q & ~step_edge; // RULE_16
			if (step_edge)
			begin
				still_q <= 1'b0; // RULE_18
			end
			else if (limit_hit)
			begin
				still_q <= 1'b1; // RULE_18
			end
		end
	end

	sine_lookup u_sine
	(
		.pos(coil_q), // RULE_04
		.coil(coil)
	);

	assign microstep_position_count = pos_q;
	assign coil_position = coil_q;
	assign standstill = still_q;
	assign standstill_event = still_event_q;
	assign standby_active = still_q & standby_select_pin; // RULE_17

	// Sequences: an edge in sync stage two, then the count moved
	sequence edge_seen_s;
		step_edge && resolution == res_q;
	endsequence

	property step_moves_p;
		@(posedge clk_sys) disable iff (reset)
		edge_seen_s |=> (pos_q == $past(pos_q) + $past(width)) || (pos_q == $past(pos_q) - $past(width));
	endproperty

	step_moves_a: assert property (step_moves_p) else $error("Step did not move by width"); // RULE_05

	dir_sign_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
		(edge_seen_s and !sync2_q.dir) |=> pos_q == 10'($past(pos_q) + $past(width)))
		else $error("Direction low did not add");

	fall_ignored_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
		!step_edge && resolution == res_q |=> pos_q == $past(pos_q))
		else $error("Position moved without rising edge");

	sync_delay_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
		$rose(step_in.step) ##1 step_in.step ##1 step_in.step && resolution == res_q && $stable(resolution)
		|-> step_edge)
		else $error("Step edge not seen two cycles after pin");

	grid_align_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_07
		resolution != res_q && resolution != 4'h0 |=> (pos_q & half_width) == half_width
		&& (pos_q & (half_width - 10'h001)) == 10'h000)
		else $error("Snapped position off grid");

	full_grid_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
		resolution == 4'h8 && res_q == 4'h8 |-> pos_q[7:0] == 8'h80)
		else $error("Full step position invalid");

	still_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_18
		still_q && step_edge |=> !still_q)
		else $error("Standstill not cleared by edge");

	still_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_16
		limit_hit && !step_edge |=> still_q)
		else $error("Standstill not set at limit");

	standby_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_17
		standby_active |-> still_q && standby_select_pin)
		else $error("Standby without standstill and select");

	pending_load_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_13
		((interp_enable && state_q == step_seq_pkg::ST_RUN) and edge_seen_s) |=> pending_q == 9'($past(width)))
		else $error("Microsteps per pulse wrong");

	half_grid_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_09
		resolution == 4'h7 && res_q == 4'h7 |-> pos_q[6:0] == 7'h40)
		else $error("Half step position invalid");

	quarter_grid_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
		resolution == 4'h6 && res_q == 4'h6 |-> pos_q[5:0] == 6'h20)
		else $error("Quarter step position invalid");

	snap_coil_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_07
		resolution != res_q |=> coil_q == pos_q)
		else $error("Coil not at snapped position");

	event_once_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_16
		still_event_q |-> still_q && !$past(still_q))
		else $error("Standstill event not a single pulse");

	microstep_one_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
		interp_enable && resolution == res_q && state_q == step_seq_pkg::ST_RUN && !step_edge && !limit_hit
		|=> coil_q == $past(coil_q) || coil_q == 10'($past(coil_q) + 10'h001)
		|| coil_q == 10'($past(coil_q) - 10'h001))
		else $error("Interpolated position jumped");

	interval_cap_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE_15
		interval_q <= 21'(INTERVAL_LIMIT))
		else $error("Interval count past its limit");
endmodule
`default_nettype wire

// >>> bench/step_source.sv
// Partner model: external motion controller issuing step pulses
`timescale 1ns/1ps
`default_nettype none
module step_source
(
	input wire logic clk_sys, // System clock
	input wire logic fire, // Request one step pulse
	input wire logic dir_req, // Direction for that pulse
	output step_seq_pkg::step_in_type pins // Step and direction pins
);
	logic [2:0] phase_q;
	initial
	begin
		phase_q = 3'h0;
		pins = '0;
	end
	always @(posedge clk_sys)
	begin
		if (phase_q != 3'h0)
			phase_q <= phase_q + 3'h1;
		else if (fire)
			phase_q <= 3'h1;
		// Three high, at least five low: rate stays well under half the clock
		pins.step <= (phase_q >= 3'h1) && (phase_q <= 3'h3);
		// Direction only moves while idle, held across the whole pulse
		if (fire && phase_q == 3'h0)
			pins.dir <= dir_req;
	end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Testbench of the step/direction microstep sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic fire = 1'b0;
	logic dir_req = 1'b0;
	logic [3:0] res = 4'h0;
	logic interp = 1'b0;
	logic sel = 1'b0;
	step_seq_pkg::step_in_type pins;
	step_seq_pkg::coil_out_type coil;
	logic [9:0] pos;
	logic [9:0] cpos;
	logic still;
	logic still_ev;
	logic standby;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	int events = 0;
	always #2.5 clk_sys = ~clk_sys;
	step_source step_source_inst (.clk_sys(clk_sys), .fire(fire), .dir_req(dir_req), .pins(pins));
	step_dir_microstep_sequencer #(.INTERVAL_LIMIT(64)) step_dir_microstep_sequencer_inst
	(
		.clk_sys(clk_sys), .reset(reset), .step_in(pins), .resolution(res), .interp_enable(interp),
		.standby_select_pin(sel), .microstep_position_count(pos), .coil_position(cpos), .coil(coil),
		.standstill(still), .standstill_event(still_ev), .standby_active(standby)
	);
	task automatic end_sim;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(negedge clk_sys)
	begin
		cycles = cycles + 1;
		if (still_ev === 1'b1)
			events = events + 1;
		if (cycles == 5000)
		begin
			errors = errors + 1;
			end_sim();
		end
	end
	task automatic chk_pos(input logic [9:0] got, input logic [9:0] exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares = compares + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic do_step(input logic d, input int n);
		@(posedge clk_sys);
		fire <= 1'b1;
		dir_req <= d;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic step_chk(input logic d, input logic [9:0] exp);
		do_step(d, 9);
		@(negedge clk_sys);
		chk_pos(pos, exp);
		chk_pos(cpos, exp);
	endtask
	task automatic res_chk(input logic [3:0] r, input logic [9:0] exp);
		@(posedge clk_sys);
		res <= r;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_pos(pos, exp);
	endtask
	task automatic test_fine;
		@(negedge clk_sys);
		chk_pos(pos, 10'h000);
		chk_bit(coil.coil_b[8], 1'b0);
		do_step(1'b0, 0);
		wait (pins.step === 1'b1);
		@(negedge clk_sys);
		chk_pos(pos, 10'h000);
		repeat (9) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_pos(pos, 10'h001);
		step_chk(1'b1, 10'h000);
		step_chk(1'b1, 10'h3FF);
		step_chk(1'b0, 10'h000);
	endtask
	task automatic test_grid;
		step_chk(1'b0, 10'h001);
		res_chk(4'h8, 10'h080);
		chk_bit(coil.coil_a[8], 1'b0);
		chk_bit(coil.coil_b[8], 1'b0);
		step_chk(1'b0, 10'h180);
		step_chk(1'b0, 10'h280);
		chk_bit(coil.coil_a[8], 1'b1);
		chk_bit(coil.coil_b[8], 1'b1);
		step_chk(1'b0, 10'h380);
		step_chk(1'b0, 10'h080);
		res_chk(4'h0, 10'h080);
		step_chk(1'b1, 10'h07F);
		res_chk(4'h7, 10'h040);
		step_chk(1'b0, 10'h0C0);
		res_chk(4'h0, 10'h0C0);
		step_chk(1'b0, 10'h0C1);
		res_chk(4'h6, 10'h0E0);
		step_chk(1'b0, 10'h120);
	endtask
	task automatic test_still;
		int e0;
		e0 = events;
		repeat (80) @(posedge clk_sys);
		@(negedge clk_sys);
		chk_bit(still, 1'b1);
		chk_bit(events - e0 == 1, 1'b1);
		chk_bit(standby, 1'b0);
		@(posedge clk_sys);
		sel <= 1'b1;
		@(negedge clk_sys);
		chk_bit(standby, 1'b1);
		step_chk(1'b1, 10'h0E0);
		chk_bit(still, 1'b0);
	endtask
	task automatic interp_case(input logic [3:0] r, input logic [9:0] snap, input logic [9:0] fin);
		int changes;
		logic [9:0] last;
		changes = 0;
		res_chk(r, snap);
		do_step(1'b0, 46);
		do_step(1'b0, 46);
		do_step(1'b0, 0);
		@(negedge clk_sys);
		last = cpos;
		repeat (55)
		begin
			@(negedge clk_sys);
			if (cpos !== last)
				changes = changes + 1;
			last = cpos;
		end
		chk_pos(pos, fin);
		chk_pos(cpos, fin);
		chk_bit(changes > 1, 1'b1);
	endtask
	initial
	begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		test_fine();
		test_grid();
		test_still();
		res_chk(4'h0, 10'h0E0);
		step_chk(1'b0, 10'h0E1);
		@(posedge clk_sys);
		interp <= 1'b1;
		interp_case(4'h1, 10'h0E1, 10'h0E7);
		interp_case(4'h2, 10'h0E6, 10'h0F2);
		end_sim();
	end
endmodule
`default_nettype wire
